/* design/nv_store_pkg.sv */
package nv_store_pkg;
	// Direct register addresses in sector 0
	localparam logic [7:0] ADDR_PTR1_LOW = 8'h01;
	localparam logic [7:0] ADDR_PTR1_HIGH = 8'h02;
	localparam logic [7:0] ADDR_PTR2_LOW = 8'h03;
	localparam logic [7:0] ADDR_PTR2_HIGH = 8'h04;
	localparam logic [7:0] ADDR_INDIRECT1 = 8'h05;
	localparam logic [7:0] ADDR_INDIRECT2 = 8'h06;
	localparam logic [7:0] ADDR_NV_BYTE_ADDRESS = 8'h07;
	localparam logic [7:0] ADDR_NV_BYTE_DATA = 8'h08;
	// Control register location, reached only through a pointer pair
	localparam logic [7:0] CTRL_PTR_LOW = 8'h40;
	localparam logic [7:0] CTRL_PTR_HIGH = 8'h01;
	// Control register fields
	localparam int BIT_RESERVED = 7;
	localparam int BIT_STORE_GATE = 3;
	localparam int BIT_WRITE_TRIG = 2;
	localparam int BIT_FETCH_GATE = 1;
	localparam int BIT_READ_TRIG = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int STORE_DEPTH = 256;
	// Timing
	localparam int READ_CYCLES = 4;
	localparam logic [2:0] READ_CYCLES_W = 3'(READ_CYCLES);
	localparam int WRITE_SUB_EDGES = 8;
	localparam logic [3:0] WRITE_SUB_EDGES_W = 4'(WRITE_SUB_EDGES);

	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic global_en;
		logic nv_en;
		logic mf_en;
		logic stack_full;
	} irq_enables_t;
endpackage : nv_store_pkg

/* design/eeprom_byte_access_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Store holds 256 bytes; each access moves one byte via address and data.
// - Control register sits at 40H, sector 1, reached only by pointer pair.
// - Store gate bit 3 must be one before any write can start.
// - Write trigger bit 2 starts a write only if gate already set; auto-clears.
// - Fetch gate bit 1 must be one before any read can start.
// - Read trigger bit 0 starts a read if gate set; clears when data valid.
// - Bit 7 reserved, software keeps zero; bits 6 to 4 read as zero.
// - Data register keeps the fetched byte until the next read or write.
// - Write timed by subsidiary clock edges; done shown by trigger clear or flag.
// - Reset clears the store gate and both pointer high bytes.
// - Write end sets the store flag and the multi-function flag.
// - Vector request only with all three enables set and stack not full.
// - Service clears multi-function flag and global enable; software clears store flag.
module eeprom_byte_access_ctrl (
	input wire logic clock, // 20 MHz system clock
	input wire logic rst_n, // Asynchronous reset
	input wire nv_store_pkg::bus_req_t bus_req, // CPU data-memory access
	output logic [7:0] bus_rdata, // Read data, valid cycle after re
	input wire logic sub_clk, // Subsidiary low-speed clock, asynchronous
	input wire nv_store_pkg::irq_enables_t irq_en, // Interrupt enables
	input wire logic nv_irq_flag_clr, // Software clear of store flag
	input wire logic irq_service, // Vector taken by the CPU
	output logic nv_irq_flag, // Store interrupt request flag
	output logic mf_irq_flag, // Multi-function request flag
	output logic irq_vector_req, // Request to vector
	output logic global_irq_clear // Pulse: clear global enable
);
	import nv_store_pkg::*;

	typedef enum logic [1:0] {IDLE, READING, WRITING} op_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Registers and decode

	logic [7:0] store [STORE_DEPTH];
	logic [7:0] ptr1_low_r, ptr1_high_r, ptr2_low_r, ptr2_high_r;
	logic [7:0] nv_byte_address_r, nv_byte_data_r;
	logic reserved_r, store_gate_r, fetch_gate_r, write_busy_r, read_busy_r;
	op_state_t state_r;
	logic [2:0] read_cnt_r;
	logic [3:0] sub_edges_r;
	logic sub_meta_r, sub_sync_r, sub_prev_r;
	logic [7:0] ctrl_view;
	logic ind1_ctrl, ind2_ctrl, ctrl_hit_w, ctrl_we;
	logic start_write, start_read, write_done, read_done, sub_edge;

	// Only a pointer pair holding sector 1, offset 40H reaches the control byte
	assign ind1_ctrl = (ptr1_high_r == CTRL_PTR_HIGH) && (ptr1_low_r == CTRL_PTR_LOW);
	assign ind2_ctrl = (ptr2_high_r == CTRL_PTR_HIGH) && (ptr2_low_r == CTRL_PTR_LOW);
	assign ctrl_hit_w = ((bus_req.addr == ADDR_INDIRECT1) && ind1_ctrl) ||
		((bus_req.addr == ADDR_INDIRECT2) && ind2_ctrl);
	assign ctrl_we = bus_req.we && ctrl_hit_w;

	// Gates are sampled before this write lands, so setting gate and trigger together fails
	assign start_write = ctrl_we && bus_req.wdata[BIT_WRITE_TRIG] && store_gate_r &&
		(state_r == IDLE);
	assign start_read = ctrl_we && bus_req.wdata[BIT_READ_TRIG] && fetch_gate_r &&
		(state_r == IDLE) && !start_write;

	assign ctrl_view = {reserved_r, 3'h0, store_gate_r, write_busy_r, fetch_gate_r,
		read_busy_r};

	////////////////////////////////////////////////////////////////////////////////
	// Pointer registers

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ptr1_low_r <= 8'h00;
			ptr1_high_r <= 8'h00;
			ptr2_low_r <= 8'h00;
			ptr2_high_r <= 8'h00;
		end else if (bus_req.we) begin
			if (bus_req.addr == ADDR_PTR1_LOW) ptr1_low_r <= bus_req.wdata;
			if (bus_req.addr == ADDR_PTR1_HIGH) ptr1_high_r <= bus_req.wdata;
			if (bus_req.addr == ADDR_PTR2_LOW) ptr2_low_r <= bus_req.wdata;
			if (bus_req.addr == ADDR_PTR2_HIGH) ptr2_high_r <= bus_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address and data registers

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nv_byte_address_r <= RESET_BYTE;
		end else if (bus_req.we && bus_req.addr == ADDR_NV_BYTE_ADDRESS) begin
			nv_byte_address_r <= bus_req.wdata;
		end
	end

	// Fetched byte wins over a CPU write in the same cycle; it stays until next op
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nv_byte_data_r <= RESET_BYTE;
		end else if (read_done) begin
			nv_byte_data_r <= store[nv_byte_address_r];
		end else if (bus_req.we && bus_req.addr == ADDR_NV_BYTE_DATA) begin
			nv_byte_data_r <= bus_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reserved_r <= 1'b0;
			store_gate_r <= 1'b0;
			fetch_gate_r <= 1'b0;
		end else if (ctrl_we) begin
			reserved_r <= bus_req.wdata[BIT_RESERVED];
			store_gate_r <= bus_req.wdata[BIT_STORE_GATE];
			fetch_gate_r <= bus_req.wdata[BIT_FETCH_GATE];
		end
	end

	// Trigger bits show busy; a write of zero cannot abort a running cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			write_busy_r <= 1'b0;
			read_busy_r <= 1'b0;
		end else begin
			if (start_write) write_busy_r <= 1'b1;
			else if (write_done) write_busy_r <= 1'b0;
			if (start_read) read_busy_r <= 1'b1;
			else if (read_done) read_busy_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Subsidiary clock synchroniser and edge detect

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sub_meta_r <= 1'b0;
			sub_sync_r <= 1'b0;
			sub_prev_r <= 1'b0;
		end else begin
			sub_meta_r <= sub_clk;
			sub_sync_r <= sub_meta_r;
			sub_prev_r <= sub_sync_r;
		end
	end

	assign sub_edge = sub_sync_r && !sub_prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// Operation sequencer

	assign read_done = (state_r == READING) && (read_cnt_r == READ_CYCLES_W - 3'd1);
	assign write_done = (state_r == WRITING) && sub_edge &&
		(sub_edges_r == WRITE_SUB_EDGES_W - 4'd1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= IDLE;
			read_cnt_r <= 3'h0;
			sub_edges_r <= 4'h0;
		end else begin
			case (state_r)
				IDLE: begin
					read_cnt_r <= 3'h0;
					sub_edges_r <= 4'h0;
					if (start_write) state_r <= WRITING;
					else if (start_read) state_r <= READING;
				end
				READING: begin
					read_cnt_r <= read_cnt_r + 3'd1;
					if (read_done) state_r <= IDLE;
				end
				WRITING: begin
					// Length varies in system cycles since the timer follows the slow clock
					if (sub_edge) sub_edges_r <= sub_edges_r + 4'd1;
					if (write_done) state_r <= IDLE;
				end
				default: state_r <= IDLE;
			endcase
		end
	end

	// Array has no reset so it maps onto plain storage
	always_ff @(posedge clock) begin
		if (write_done) begin
			store[nv_byte_address_r] <= nv_byte_data_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.re) begin
			if (ctrl_hit_w) bus_rdata <= ctrl_view;
			else begin
				case (bus_req.addr)
					ADDR_PTR1_LOW: bus_rdata <= ptr1_low_r;
					ADDR_PTR1_HIGH: bus_rdata <= ptr1_high_r;
					ADDR_PTR2_LOW: bus_rdata <= ptr2_low_r;
					ADDR_PTR2_HIGH: bus_rdata <= ptr2_high_r;
					ADDR_NV_BYTE_ADDRESS: bus_rdata <= nv_byte_address_r;
					ADDR_NV_BYTE_DATA: bus_rdata <= nv_byte_data_r;
					default: bus_rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt flags

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nv_irq_flag <= 1'b0;
			mf_irq_flag <= 1'b0;
			global_irq_clear <= 1'b0;
		end else begin
			if (write_done) nv_irq_flag <= 1'b1;
			else if (nv_irq_flag_clr) nv_irq_flag <= 1'b0;
			if (write_done) mf_irq_flag <= 1'b1;
			else if (irq_service) mf_irq_flag <= 1'b0;
			global_irq_clear <= irq_service;
		end
	end

	assign irq_vector_req = irq_en.global_en && irq_en.nv_en && irq_en.mf_en &&
		mf_irq_flag && nv_irq_flag && !irq_en.stack_full;

endmodule : eeprom_byte_access_ctrl

`default_nettype wire

/* dv/nv_store_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module nv_store_checker (
	input wire logic clock, // system clock
	input wire logic rst_n, // async reset
	input wire nv_store_pkg::bus_req_t bus_req, // CPU access
	input wire logic [7:0] bus_rdata, // read data
	input wire logic sub_clk, // slow clock
	input wire nv_store_pkg::irq_enables_t irq_en, // enables
	input wire logic nv_irq_flag_clr, // store flag clear
	input wire logic irq_service, // vector taken
	input wire logic nv_irq_flag, // store flag
	input wire logic mf_irq_flag, // multi-function flag
	input wire logic irq_vector_req, // vector request
	input wire logic global_irq_clear // enable clear pulse
);
	import nv_store_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	sequence s_service;
		irq_service ##1 global_irq_clear;
	endsequence
	property p_vector;
		irq_vector_req == (irq_en.global_en && irq_en.nv_en && irq_en.mf_en
			&& mf_irq_flag && nv_irq_flag && !irq_en.stack_full);
	endproperty
	property p_service;
		irq_service |-> s_service;
	endproperty
	property p_clr_cause;
		global_irq_clear |-> $past(irq_service);
	endproperty
	property p_clr_pulse;
		global_irq_clear && !irq_service |=> !global_irq_clear;
	endproperty
	// Set wins over clear, so only checked with the store flag already up
	property p_mf_clr;
		irq_service && nv_irq_flag && mf_irq_flag |=> !mf_irq_flag;
	endproperty
	property p_nv_keep;
		irq_service && nv_irq_flag && !nv_irq_flag_clr |=> nv_irq_flag;
	endproperty
	property p_pair;
		$rose(nv_irq_flag) |-> mf_irq_flag;
	endproperty
	property p_rdata_hold;
		!bus_req.re |=> $stable(bus_rdata);
	endproperty
	////////////////////////////////////////////////////////////////////////
	a_vector: assert property (p_vector) else $error("vector request mismatch");
	a_service: assert property (p_service) else $error("no enable clear");
	a_clr_cause: assert property (p_clr_cause) else $error("stray clear");
	a_clr_pulse: assert property (p_clr_pulse) else $error("clear too long");
	a_mf_clr: assert property (p_mf_clr) else $error("mf flag kept");
	a_nv_keep: assert property (p_nv_keep) else $error("store flag lost");
	a_pair: assert property (p_pair) else $error("flags not paired");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : nv_store_checker
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import nv_store_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	bus_req_t bus_req = '0;
	irq_enables_t irq_en = '0;
	logic sub_clk = 1'b0;
	logic nv_irq_flag_clr = 1'b0;
	logic irq_service = 1'b0;
	logic [7:0] bus_rdata;
	logic nv_irq_flag, mf_irq_flag, irq_vector_req, global_irq_clear;
	logic [7:0] v;
	logic [7:0] tv [3] = '{8'h04, 8'h01, 8'h70};
	int n_mismatch = 0;
	int checks = 0;
	always #25 clock = ~clock;
	// Free-running, so always stable before a write; phase unrelated to clock
	always #330 sub_clk = ~sub_clk;
	eeprom_byte_access_ctrl eeprom_byte_access_ctrl_i (.clock(clock), .rst_n(rst_n),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .sub_clk(sub_clk), .irq_en(irq_en),
		.nv_irq_flag_clr(nv_irq_flag_clr), .irq_service(irq_service),
		.nv_irq_flag(nv_irq_flag), .mf_irq_flag(mf_irq_flag),
		.irq_vector_req(irq_vector_req), .global_irq_clear(global_irq_clear));
	////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{we: we, re: !we, addr: a, wdata: d};
		@(posedge clock);
	endtask : acc
	task automatic idle;
		bus_req <= '0;
		@(posedge clock);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
		idle();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		acc(1'b0, a, 8'h00);
		idle();
		r = bus_rdata;
	endtask : rd
	task automatic poll(input int b);
		for (int i = 0; i < 300; i++) begin
			rd(ADDR_INDIRECT1, v);
			if (v[b] === 1'b0) break;
		end
		`CHK(v[b], 1'b0)
	endtask : poll
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(ADDR_PTR1_HIGH, v); `CHK(v, 8'h00)
		rd(ADDR_NV_BYTE_DATA, v); `CHK(v, 8'h00)
		wr(ADDR_PTR1_LOW, CTRL_PTR_LOW);
		wr(ADDR_PTR1_HIGH, CTRL_PTR_HIGH);
		rd(ADDR_INDIRECT1, v); `CHK(v, 8'h00)
		$display("test reset done");
		foreach (tv[i]) begin
			wr(ADDR_INDIRECT1, tv[i]);
			rd(ADDR_INDIRECT1, v); `CHK(v, 8'h00)
		end
		$display("test refusals done");
		wr(ADDR_NV_BYTE_ADDRESS, 8'hff);
		wr(ADDR_NV_BYTE_DATA, 8'ha5);
		acc(1'b1, ADDR_INDIRECT1, 8'h08);
		acc(1'b1, ADDR_INDIRECT1, 8'h0c);
		idle();
		rd(ADDR_INDIRECT1, v); `CHK(v, 8'h0c)
		poll(BIT_WRITE_TRIG);
		`CHK({nv_irq_flag, mf_irq_flag}, 2'b11)
		wr(ADDR_PTR2_LOW, CTRL_PTR_LOW);
		wr(ADDR_PTR2_HIGH, CTRL_PTR_HIGH);
		rd(ADDR_INDIRECT2, v); `CHK(v, 8'h08)
		$display("test write done");
		irq_en <= '{global_en: 1'b1, nv_en: 1'b1, mf_en: 1'b1, stack_full: 1'b1};
		idle();
		`CHK(irq_vector_req, 1'b0)
		irq_en.stack_full <= 1'b0;
		idle();
		`CHK(irq_vector_req, 1'b1)
		irq_service <= 1'b1;
		idle();
		irq_service <= 1'b0;
		// Pulse launched at this edge; look once it has settled
		#1 `CHK(global_irq_clear, 1'b1)
		idle();
		`CHK({nv_irq_flag, mf_irq_flag}, 2'b10)
		nv_irq_flag_clr <= 1'b1;
		idle();
		nv_irq_flag_clr <= 1'b0;
		idle();
		`CHK(nv_irq_flag, 1'b0)
		$display("test interrupt done");
		// Overwrite the data register so only a real fetch brings back the stored byte
		wr(ADDR_NV_BYTE_DATA, 8'h3c);
		wr(ADDR_NV_BYTE_ADDRESS, 8'hff);
		wr(ADDR_INDIRECT1, 8'h02);
		acc(1'b1, ADDR_INDIRECT1, 8'h03);
		idle();
		poll(BIT_READ_TRIG);
		rd(ADDR_NV_BYTE_DATA, v); `CHK(v, 8'ha5)
		repeat (5) idle();
		rd(ADDR_NV_BYTE_DATA, v); `CHK(v, 8'ha5)
		$display("test read done");
		wrap_up();
	end
endmodule : tb_top
bind eeprom_byte_access_ctrl nv_store_checker nv_store_checker_i (.clock(clock),
	.rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .sub_clk(sub_clk),
	.irq_en(irq_en), .nv_irq_flag_clr(nv_irq_flag_clr), .irq_service(irq_service),
	.nv_irq_flag(nv_irq_flag), .mf_irq_flag(mf_irq_flag),
	.irq_vector_req(irq_vector_req), .global_irq_clear(global_irq_clear));
`default_nettype wire
